// ==== sld_ctrl_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module sld_ctrl_model (
    // Bench clock
    input  wire logic clk,
    // Pins toward the driver
    output var  logic shift_clk,
    output var  logic serial_in,
    output var  logic load_strobe,
    output var  logic out_enable_n
);
    initial begin
        shift_clk    = 1'b0;
        serial_in    = 1'b0;
        load_strobe  = 1'b0;
        out_enable_n = 1'b1;
    end

    // Four bench cycles per phase gives a 160 ns link period
    task automatic send_bit(input logic v);
        serial_in = v;
        repeat (4) @(negedge clk);
        shift_clk = 1'b1;
        repeat (4) @(negedge clk);
        shift_clk = 1'b0;
    endtask

    // Most significant bit first, so bit i lands in stage i
    task automatic send_byte(input logic [7:0] b);
        int i;
        for (i = 7; i >= 0; i--) begin
            send_bit(b[i]);
        end
        // Line not pulled: show the inverse once released
        serial_in = ~serial_in;
    endtask

    task automatic strobe_on;
        load_strobe = 1'b1;
    endtask

    task automatic strobe_off;
        load_strobe = 1'b0;
    endtask

    task automatic blank_on;
        out_enable_n = 1'b1;
    endtask

    task automatic blank_off;
        out_enable_n = 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== sld_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module sld_fifo #(
    parameter int unsigned WIDTH = 1,
    parameter int unsigned DEPTH = 8
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // Fill side
    sld_stream_if.snk wr,
    // Drain side
    sld_stream_if.src rd
);
    import sld_pkg::*;

    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int unsigned CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

    logic [WIDTH-1:0] mem      [DEPTH];
    logic [WIDTH-1:0] next_mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [CW-1:0]    count;
    logic [PW-1:0]    next_wr_ptr;
    logic [PW-1:0]    next_rd_ptr;
    logic [CW-1:0]    next_count;
    logic             push;
    logic             pop;

    assign wr.ready = (count != CW'(DEPTH));
    assign rd.valid = (count != '0);
    assign rd.data  = mem[rd_ptr];
    assign push     = wr.valid && wr.ready;
    assign pop      = rd.valid && rd.ready;

    always_comb begin
        next_mem    = mem;
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count  = count;
        if (push) begin
            next_mem[wr_ptr] = wr.data;
            next_wr_ptr      = (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
        end
        if (pop) begin
            next_rd_ptr = (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            mem    <= next_mem;
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end

    fifo_full_a: assert property (@(posedge clk) disable iff (!arst_n)
        count == CW'(DEPTH) |-> !wr.ready)
        else $error("fifo accepts data while full");
    fifo_count_a: assert property (@(posedge clk) disable iff (!arst_n)
        push && !pop |=> count == $past(count) + 1'b1)
        else $error("fifo count did not grow on push");
    fifo_fill_c: cover property (@(posedge clk) disable iff (!arst_n)
        count == CW'(DEPTH));
endmodule
`default_nettype wire

// ==== sld_pkg.sv ====
package sld_pkg;
    // Shift register, latch and sink driver count
    localparam int unsigned SHIFT_WIDTH      = 8;
    // One-bit-wide buffer between pin sampling and shift register
    localparam int unsigned FIFO_WIDTH       = 1;
    localparam int unsigned FIFO_DEPTH       = 8;
    // Pin input vector positions
    localparam int unsigned PIN_COUNT        = 4;
    localparam int unsigned PIN_SHIFT_CLK    = 0;
    localparam int unsigned PIN_SERIAL_IN    = 1;
    localparam int unsigned PIN_LOAD_STROBE  = 2;
    localparam int unsigned PIN_OUT_ENABLE_N = 3;
    // Pull-up on output enable, pull-down on the others
    localparam logic [3:0]  PIN_RESET        = 4'h8;
    localparam logic [7:0]  SHIFT_RESET      = 8'h00;
    localparam logic [7:0]  LATCH_RESET      = 8'h00;
    localparam logic [7:0]  SINK_OFF         = 8'h00;
    // Timing
    localparam int unsigned CLK_PERIOD_NS    = 20;
    localparam int unsigned CASCADE_MAX_MHZ  = 10;
    localparam int unsigned CASCADE_MIN_NS   = 1000 / CASCADE_MAX_MHZ;
    localparam int unsigned CASCADE_MIN_CYC  =
        (CASCADE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ==== sld_serial_sink_driver.sv ====
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Each rising shift clock edge that finds room in the buffer moves the register one stage, serial input first.
// - While load strobe is high each latch takes its shift stage.
// - Latches stay transparent and follow the register while strobe stays high.
// - High strobe captures data; latches hold while strobe is low.
// - Blanking input high forces all eight sink outputs off.
// - Blanking never alters latch contents; it acts on drivers only.
// - Blanking low lets each sink output follow its own latch.
// - Eight sink outputs zero to seven, one per latch and stage.
// - Push-pull serial output presents shift data for the next device.
// - Blanking input pulled up, so unconnected means outputs off.
// - Strobe input pulled down, so unconnected means latches hold.
module sld_serial_sink_driver
    import sld_pkg::*;
#(
    parameter int unsigned WIDTH = sld_pkg::SHIFT_WIDTH,
    parameter int unsigned DEPTH = sld_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             arst_n,
    // Serial link pins
    input  wire logic             shift_clk,
    input  wire logic             serial_in,
    input  wire logic             load_strobe,
    input  wire logic             out_enable_n,
    output var  logic             serial_out,
    // Sink drivers, one per latch
    output var  logic [WIDTH-1:0] sink_driver_lines,
    // Buffer control
    input  wire logic             shift_hold,
    output var  logic             capture_ready
);
    import sld_pkg::*;

    // Pin synchronisers and agreement filter
    logic [PIN_COUNT-1:0] sync1;
    logic [PIN_COUNT-1:0] sync2;
    logic [PIN_COUNT-1:0] sync3;
    logic [PIN_COUNT-1:0] lvl;
    logic [PIN_COUNT-1:0] pins;
    logic [PIN_COUNT-1:0] next_lvl;

    assign pins = {out_enable_n, load_strobe, serial_in, shift_clk};

    // A change is taken only once the second and third stages agree
    always_comb begin
        next_lvl = (sync2 & sync3) | (lvl & (sync2 | sync3));
    end

    // Reset values model the pin pulls until the first real samples arrive
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1 <= PIN_RESET;
            sync2 <= PIN_RESET;
            sync3 <= PIN_RESET;
            lvl   <= PIN_RESET;
        end else begin
            sync1 <= pins;
            sync2 <= sync1;
            sync3 <= sync2;
            lvl   <= next_lvl;
        end
    end

    logic shift_edge;
    logic strobe_hi;
    logic blanked;

    // Data and clock share the same delay, so data is sampled at the edge
    assign shift_edge = next_lvl[PIN_SHIFT_CLK] && !lvl[PIN_SHIFT_CLK];
    assign strobe_hi  = lvl[PIN_LOAD_STROBE];
    assign blanked    = lvl[PIN_OUT_ENABLE_N];

    // Captured bits wait here while the consumer stalls; edges arriving once it is full are dropped
    sld_stream_if #(.WIDTH(FIFO_WIDTH)) cap_bus ();
    sld_stream_if #(.WIDTH(FIFO_WIDTH)) shf_bus ();

    assign cap_bus.valid = shift_edge;
    assign cap_bus.data  = next_lvl[PIN_SERIAL_IN];
    assign capture_ready = cap_bus.ready;
    assign shf_bus.ready = !shift_hold;

    sld_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk   (clk),
        .arst_n(arst_n),
        .wr    (cap_bus),
        .rd    (shf_bus)
    );

    logic             shift_pop;
    logic [WIDTH-1:0] shift_reg;
    logic [WIDTH-1:0] latch;
    logic [WIDTH-1:0] next_shift_reg;
    logic [WIDTH-1:0] next_latch;
    logic [WIDTH-1:0] next_sink;
    logic             next_serial_out;

    assign shift_pop = shf_bus.valid && shf_bus.ready;

    always_comb begin
        next_shift_reg  = shift_reg;
        next_latch      = latch;
        next_serial_out = serial_out;
        if (shift_pop) begin
            next_shift_reg  = {shift_reg[WIDTH-2:0], shf_bus.data};
            next_serial_out = shift_reg[WIDTH-2];
        end
        // Transparent while high, one cycle behind the register
        if (strobe_hi) begin
            next_latch = shift_reg;
        end
    end

    // One gate per driver line; blanking never reaches the latches
    for (genvar g = 0; g < WIDTH; g++) begin : g_sink
        assign next_sink[g] = latch[g] && !blanked;
    end

    // Cycles since the last shift edge, for the link rate watch
    // Saturates, so a long idle gap never wraps into a false short one
    logic [3:0] edge_gap;
    logic [3:0] next_edge_gap;

    always_comb begin
        next_edge_gap = edge_gap;
        if (shift_edge) begin
            next_edge_gap = 4'h0;
        end else if (edge_gap != 4'hf) begin
            next_edge_gap = edge_gap + 4'h1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            edge_gap <= 4'hf;
        end else begin
            edge_gap <= next_edge_gap;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            shift_reg         <= SHIFT_RESET;
            latch             <= LATCH_RESET;
            serial_out        <= 1'b0;
            sink_driver_lines <= SINK_OFF;
        end else begin
            shift_reg         <= next_shift_reg;
            latch             <= next_latch;
            serial_out        <= next_serial_out;
            sink_driver_lines <= next_sink;
        end
    end

    shift_step_a: assert property (@(posedge clk) disable iff (!arst_n)
        shift_pop |=> shift_reg == {$past(shift_reg[WIDTH-2:0]), $past(shf_bus.data)})
        else $error("shift register did not advance by one stage");
    latch_follow_a: assert property (@(posedge clk) disable iff (!arst_n)
        strobe_hi ##1 strobe_hi |=> latch == $past(shift_reg))
        else $error("latch not transparent while strobe high");
    latch_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
        !strobe_hi |=> $stable(latch))
        else $error("latch changed while strobe low");
    blank_off_a: assert property (@(posedge clk) disable iff (!arst_n)
        blanked |=> sink_driver_lines == SINK_OFF)
        else $error("sink outputs on while blanked");
    blank_keeps_a: assert property (@(posedge clk) disable iff (!arst_n)
        !strobe_hi && $changed(blanked) |=> latch == $past(latch))
        else $error("blanking disturbed the latches");
    drive_map_a: assert property (@(posedge clk) disable iff (!arst_n)
        !blanked |=> sink_driver_lines == $past(latch))
        else $error("sink outputs do not follow latches");
    serial_last_a: assert property (@(posedge clk) disable iff (!arst_n)
        shift_pop |=> serial_out == shift_reg[WIDTH-1])
        else $error("serial output is not the last stage");
    edge_gap_a: assert property (@(posedge clk) disable iff (!arst_n)
        shift_edge |=> !shift_edge [*4])
        else $error("shift clock edges closer than cascade limit");
    load_path_a: assert property (@(posedge clk) disable iff (!arst_n)
        strobe_hi && !blanked ##1 !blanked |=> sink_driver_lines == $past(shift_reg, 2))
        else $error("strobe did not carry register to outputs");

    // Register and serial output stand between shifts
    shift_stand_a: assert property (@(posedge clk) disable iff (!arst_n)
        !shift_pop |=> $stable(shift_reg))
        else $error("shift register moved without a shift");
    serial_stand_a: assert property (@(posedge clk) disable iff (!arst_n)
        !shift_pop |=> $stable(serial_out))
        else $error("serial output moved without a shift");
    serial_stage_a: assert property (@(posedge clk) disable iff (!arst_n)
        shift_pop |=> serial_out == $past(shift_reg[WIDTH-2]))
        else $error("serial output is not the shifted stage");
    strobe_take_a: assert property (@(posedge clk) disable iff (!arst_n)
        strobe_hi |=> latch == $past(shift_reg))
        else $error("latch did not take the register while strobe high");
    blank_latch_a: assert property (@(posedge clk) disable iff (!arst_n)
        blanked && !strobe_hi |=> $stable(latch))
        else $error("latch changed while blanked and strobe low");
    unblank_map_a: assert property (@(posedge clk) disable iff (!arst_n)
        $fell(blanked) |=> sink_driver_lines == $past(latch))
        else $error("sinks wrong after blanking released");

    // Edge spacing is judged on the filtered clock, not on the pin
    edge_rate_a: assert property (@(posedge clk) disable iff (!arst_n)
        shift_edge |-> edge_gap >= 4'(CASCADE_MIN_CYC - 1))
        else $error("shift clock edges faster than cascade rate");

    shift_edge_c: cover property (@(posedge clk) disable iff (!arst_n) shift_edge);
    strobe_rise_c: cover property (@(posedge clk) disable iff (!arst_n) $rose(strobe_hi));
    lit_c: cover property (@(posedge clk) disable iff (!arst_n)
        !blanked && sink_driver_lines != SINK_OFF);
    stall_c: cover property (@(posedge clk) disable iff (!arst_n)
        shift_edge && !capture_ready);
endmodule
`default_nettype wire

// ==== sld_stream_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface sld_stream_if #(
    parameter int unsigned WIDTH = 1
);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ==== tb_serial_latched_sink_driver.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb_serial_latched_sink_driver;
    import sld_pkg::*;
    typedef struct {int sel; logic [7:0] val; string nm;} sld_note_type;
    logic         clk = 1'b0;
    logic         arst_n = 1'b0;
    logic         shift_hold = 1'b0;
    logic         shift_clk, serial_in, load_strobe, out_enable_n;
    logic         serial_out, capture_ready;
    logic [7:0]   sink_driver_lines;
    int           fail_count = 0;
    int           n_compared = 0;
    sld_note_type note_q[$];
    event         note_ev;

    initial forever #10 clk = ~clk;

    sld_ctrl_model u_ctrl (.clk(clk), .shift_clk(shift_clk), .serial_in(serial_in),
        .load_strobe(load_strobe), .out_enable_n(out_enable_n));

    sld_serial_sink_driver u_dut (.clk(clk), .arst_n(arst_n),
        .shift_clk(shift_clk), .serial_in(serial_in), .load_strobe(load_strobe),
        .out_enable_n(out_enable_n), .serial_out(serial_out),
        .sink_driver_lines(sink_driver_lines), .shift_hold(shift_hold),
        .capture_ready(capture_ready));

    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic note(input int sel, input logic [7:0] v, input string nm);
        note_q.push_back('{sel, v, nm});
        -> note_ev;
        @(negedge clk);
    endtask

    // Longest pin-to-output path is seven cycles
    task automatic settle;
        repeat (10) @(negedge clk);
    endtask

    task automatic pulse_strobe;
        u_ctrl.strobe_on;
        settle;
        u_ctrl.strobe_off;
        settle;
    endtask

    initial begin
        sld_note_type n;
        logic [7:0]   got;
        forever begin
            @(note_ev);
            n = note_q.pop_front();
            got = (n.sel == 0) ? sink_driver_lines :
                  {7'h00, (n.sel == 1) ? serial_out : capture_ready};
            `CHECK(n.nm, n.val, got)
        end
    end

    initial begin
        #100us;
        fail_count++;
        conclude;
    end

    initial begin
        logic [7:0] b;
        logic [7:0] lat;
        int i;
        void'($urandom(32'hb7cc));
        repeat (8) @(negedge clk);
        arst_n = 1'b1;
        settle;
        note(0, 8'h00, "sinks after reset");
        note(2, 8'h01, "ready after reset");
        u_ctrl.blank_off;
        lat = 8'h00;
        for (i = 0; i < 3; i++) begin
            b = 8'($urandom);
            u_ctrl.send_byte(b);
            settle;
            note(0, lat, "sinks holding");
            note(1, {7'h00, b[7]}, "serial out");
            pulse_strobe;
            lat = b;
            note(0, b, "sinks latched");
            u_ctrl.blank_on;
            settle;
            note(0, 8'h00, "sinks blanked");
            u_ctrl.blank_off;
            settle;
            note(0, b, "sinks unblanked");
        end
        // Latches bypassed: blank while data enters
        u_ctrl.blank_on;
        u_ctrl.strobe_on;
        lat = ~lat;
        u_ctrl.send_byte(lat);
        settle;
        note(0, 8'h00, "sinks blanked in bypass");
        u_ctrl.blank_off;
        settle;
        note(0, lat, "sinks transparent");
        u_ctrl.strobe_off;
        // Stall the buffer, overfill it by one bit, then drain
        shift_hold = 1'b1;
        b = 8'($urandom);
        u_ctrl.send_byte(b);
        settle;
        note(2, 8'h00, "ready when full");
        u_ctrl.send_bit(~b[0]);
        settle;
        note(0, lat, "sinks during stall");
        shift_hold = 1'b0;
        settle;
        note(2, 8'h01, "ready after drain");
        pulse_strobe;
        note(0, b, "sinks after drain");
        note(1, {7'h00, b[7]}, "serial out after drain");
        conclude;
    end
endmodule
`default_nettype wire
